// >>> sglcap_pkg.sv
// package for the scatter-gather capability report block
package sglcap_pkg;
  localparam int unsigned SGLCAP_ADDR_W = 12;
  localparam logic [11:0] SGLCAP_CAP_OFF = 12'h218;
  localparam logic [11:0] SGLCAP_RSV0_LO = 12'h21c;
  localparam logic [11:0] SGLCAP_NAME_LO = 12'h300;
  localparam logic [11:0] SGLCAP_NAME_HI = 12'h3ff;
  localparam logic [11:0] SGLCAP_RSV1_HI = 12'h6ff;
  localparam logic [11:0] SGLCAP_CTRL_OFF = 12'h800;
  localparam logic [11:0] SGLCAP_STAT_OFF = 12'h804;
  localparam int unsigned SGLCAP_NAME_WORDS = 64;
  localparam int unsigned SGLCAP_BIT_SGL = 0;
  localparam int unsigned SGLCAP_BIT_KEYED = 2;
  localparam int unsigned SGLCAP_BIT_BUCKET = 16;
  localparam int unsigned SGLCAP_BIT_MBUF = 17;
  localparam int unsigned SGLCAP_BIT_LONG = 18;
  localparam int unsigned SGLCAP_BIT_MSEG = 19;
  localparam int unsigned SGLCAP_BIT_OFFS = 20;
  localparam logic [6:0] SGLCAP_CTRL_RST = 7'h00;
  localparam logic [31:0] SGLCAP_CAP_MASK = 32'h001f0005;
  localparam logic [31:0] SGLCAP_ZERO = 32'h00000000;
endpackage : sglcap_pkg

// >>> sglcap_apb_if.sv
// interface between the apb slave front end and the capability core
`timescale 1ns/1ps
`default_nettype none
interface sglcap_apb_if;
  logic rd_req;
  logic wr_req;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [3:0] strb;
  modport front (output rd_req, output wr_req, output addr, output wdata, output strb);
  modport core (input rd_req, input wr_req, input addr, input wdata, input strb);
endinterface : sglcap_apb_if
`default_nettype wire

// >>> sglcap_apb_front.sv
// apb access decoder: one request pulse per access phase
`timescale 1ns/1ps
`default_nettype none
module sglcap_apb_front
  import sglcap_pkg::*;
(
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_busy,
  // core side
  sglcap_apb_if.front bus
);
  // the core answers one cycle into the access phase, so gate with busy
  always_comb begin
    bus.rd_req = i_psel && i_penable && !i_pwrite && !i_busy;
    bus.wr_req = i_psel && i_penable && i_pwrite && !i_busy;
    bus.addr = {i_paddr[11:2], 2'b00};
    bus.wdata = i_pwdata;
    bus.strb = i_pstrb;
  end
endmodule : sglcap_apb_front
`default_nettype wire

// >>> sglcap_report.sv
// scatter-gather capability word and subsystem name, readable over apb
`timescale 1ns/1ps
`default_nettype none
module sglcap_report
  import sglcap_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // capability report toward the command path
  output logic [31:0] o_sgl_capability_word,
  output logic o_exact_length_required
);
  typedef enum logic [1:0] {
    SGLCAP_IDLE = 2'b00,
    SGLCAP_DONE = 2'b01
  } sglcap_state_e;

  sglcap_apb_if bus ();
  sglcap_state_e state_q, state_d;
  logic [6:0] ctrl_q, ctrl_d;
  logic [31:0] name_q [SGLCAP_NAME_WORDS];
  logic [31:0] name_d [SGLCAP_NAME_WORDS];
  logic [31:0] cap_q, cap_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic err_q, err_d;
  logic exact_q, exact_d;
  logic [31:0] rd_val;
  logic rd_err;
  logic name_hit;
  logic [5:0] name_idx;

  sglcap_apb_front u_front (
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .i_busy(ready_q),
    .bus(bus.front)
  );

  assign name_hit = (bus.addr >= SGLCAP_NAME_LO) && (bus.addr <= SGLCAP_NAME_HI);
  assign name_idx = bus.addr[7:2];

  // capability word derives from the control bits; bit 0 clear forces all clear
  always_comb begin
    cap_d = SGLCAP_ZERO;
    if (ctrl_q[0]) begin
      cap_d[SGLCAP_BIT_SGL] = 1'b1;
      cap_d[SGLCAP_BIT_KEYED] = ctrl_q[1];
      cap_d[SGLCAP_BIT_BUCKET] = ctrl_q[2];
      cap_d[SGLCAP_BIT_MBUF] = ctrl_q[3];
      cap_d[SGLCAP_BIT_LONG] = ctrl_q[4];
      cap_d[SGLCAP_BIT_MSEG] = ctrl_q[5];
      cap_d[SGLCAP_BIT_OFFS] = ctrl_q[6];
    end
    cap_d = cap_d & SGLCAP_CAP_MASK;
    exact_d = !cap_d[SGLCAP_BIT_LONG];
  end

  // read mux: reserved ranges answer zero without error
  always_comb begin
    rd_val = SGLCAP_ZERO;
    rd_err = 1'b0;
    if (bus.addr == SGLCAP_CAP_OFF) begin
      rd_val = cap_q;
    end else if (name_hit) begin
      rd_val = name_q[name_idx];
    end else if (bus.addr >= SGLCAP_RSV0_LO && bus.addr <= SGLCAP_RSV1_HI) begin
      rd_val = SGLCAP_ZERO;
    end else if (bus.addr == SGLCAP_CTRL_OFF) begin
      rd_val = {25'h0000000, ctrl_q};
    end else if (bus.addr == SGLCAP_STAT_OFF) begin
      rd_val = {31'h00000000, exact_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    ready_d = 1'b0;
    err_d = 1'b0;
    for (int i = 0; i < SGLCAP_NAME_WORDS; i++) begin
      name_d[i] = name_q[i];
    end
    case (state_q)
      SGLCAP_IDLE: begin
        if (bus.rd_req) begin
          rdata_d = rd_val;
          err_d = rd_err;
          ready_d = 1'b1;
          state_d = SGLCAP_DONE;
        end else if (bus.wr_req) begin
          ready_d = 1'b1;
          rdata_d = SGLCAP_ZERO;
          state_d = SGLCAP_DONE;
          if (bus.addr == SGLCAP_CTRL_OFF) begin
            if (bus.strb[0]) begin
              ctrl_d = bus.wdata[6:0];
            end
          end else if (name_hit) begin
            // firmware loads the name text; the last byte is kept zero as terminator
            for (int b = 0; b < 4; b++) begin
              if (bus.strb[b]) begin
                name_d[name_idx][8*b +: 8] = bus.wdata[8*b +: 8];
              end
            end
            name_d[SGLCAP_NAME_WORDS-1][31:24] = 8'h00;
          end else if (bus.addr != SGLCAP_CAP_OFF) begin
            err_d = rd_err;
          end
        end
      end
      SGLCAP_DONE: begin
        state_d = SGLCAP_IDLE;
      end
      default: begin
        state_d = SGLCAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= SGLCAP_IDLE;
      ctrl_q <= SGLCAP_CTRL_RST;
      cap_q <= SGLCAP_ZERO;
      rdata_q <= SGLCAP_ZERO;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      exact_q <= 1'b1;
      for (int i = 0; i < SGLCAP_NAME_WORDS; i++) begin
        name_q[i] <= SGLCAP_ZERO;
      end
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      cap_q <= cap_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
      exact_q <= exact_d;
      for (int i = 0; i < SGLCAP_NAME_WORDS; i++) begin
        name_q[i] <= name_d[i];
      end
    end
  end

  assign o_pready = ready_q;
  assign o_prdata = rdata_q;
  assign o_pslverr = err_q;
  assign o_sgl_capability_word = cap_q;
  assign o_exact_length_required = exact_q;
endmodule : sglcap_report
`default_nettype wire

// >>> sglcap_report_properties.sv
// port-level checks for the capability report block
`timescale 1ns/1ps
`default_nettype none
module sglcap_report_properties
  import sglcap_pkg::*;
(
  // clock, reset and apb
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // report
  input wire logic [31:0] o_sgl_capability_word,
  input wire logic o_exact_length_required
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic rd_q;
  logic [9:0] wa_q;
  // remember kind and word index of the access taken, judged when pready answers
  always_ff @(posedge i_mclk) begin
    rd_q <= !i_srst && i_psel && i_penable && !o_pready && !i_pwrite;
    wa_q <= i_paddr[11:2];
  end
  chk_bit0_masks: assert property (!o_sgl_capability_word[0] |-> o_sgl_capability_word == 32'h0)
    else $error("capability bits set without list support");
  chk_rsv_bits_zero: assert property ((o_sgl_capability_word & ~SGLCAP_CAP_MASK) == 32'h0)
    else $error("reserved capability bit set");
  chk_exact_flag: assert property (o_exact_length_required == !o_sgl_capability_word[18])
    else $error("exact length flag disagrees with bit 18");
  chk_ready_once: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  chk_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("access not answered after one wait cycle");
  chk_err_no_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error response carries data");
  chk_name_end: assert property (o_pready && rd_q && wa_q == 10'h0ff |-> o_prdata[31:24] == 8'h0)
    else $error("name terminator byte not zero");
  chk_rsv_read: assert property (o_pready && rd_q && wa_q >= 10'h087 && wa_q <= 10'h1bf
      && (wa_q < 10'h0c0 || wa_q > 10'h0ff) |-> o_prdata == 32'h0 && !o_pslverr)
    else $error("reserved area read not zero");
  cover property (o_pslverr);
  cover property (o_sgl_capability_word[20]);
  cover property (o_pready && rd_q && wa_q == 10'h0ff);
endmodule : sglcap_report_properties
bind sglcap_report sglcap_report_properties u_chk (.i_mclk, .i_srst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr,
  .o_sgl_capability_word, .o_exact_length_required);
`default_nettype wire

// >>> sglcap_host_model.sv
// host side: sizes its descriptor lists from the capability word
`timescale 1ns/1ps
`default_nettype none
module sglcap_host_model (
  // capability seen and transfer asked
  input wire logic [31:0] i_cap,
  input wire logic [15:0] i_xfer_len,
  // list length the host builds
  output logic [15:0] o_list_len
);
  // pads only when longer lists are accepted
  assign o_list_len = i_cap[18] ? i_xfer_len + 16'h10 : i_xfer_len;
endmodule : sglcap_host_model
`default_nettype wire

// >>> sglcap_report_bench.sv
// self-checking bench for the capability report block
`timescale 1ns/1ps
`default_nettype none
module sglcap_report_bench;
  logic i_mclk = 1'h0, i_srst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, rdy, slv, exact, err;
  logic [11:0] addr = 12'h0;
  logic [31:0] wd = 32'h0, prd, cap, rd;
  logic [15:0] llen;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #12.5 i_mclk = ~i_mclk;
  sglcap_report u_dut (.i_mclk, .i_srst, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hf), .o_pready(rdy), .o_prdata(prd),
    .o_pslverr(slv), .o_sgl_capability_word(cap), .o_exact_length_required(exact));
  sglcap_host_model u_host (.i_cap(cap), .i_xfer_len(16'h40), .o_list_len(llen));
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // one transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge i_mclk);
    psel <= 1'h1; pwr <= w; addr <= a; wd <= d;
    @(posedge i_mclk);
    pen <= 1'h1;
    do @(posedge i_mclk); while (rdy !== 1'h1);
    r = prd;
    e = slv;
    psel <= 1'h0; pen <= 1'h0;
  endtask : apb
  // report outputs follow a control write one cycle after ready; settle waits two
  task automatic settle;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : settle
  task automatic s_caps;
    int bp[7] = '{0, 2, 16, 17, 18, 19, 20};
    logic [31:0] e;
    for (int k = 0; k < 7; k++) begin
      e = 32'h1 | (32'h1 << bp[k]);
      apb(1'h1, 12'h800, 32'h1 | (32'h1 << k), rd, err);
      settle();
      cmp(cap, e);
      cmp({31'h0, exact}, {31'h0, ~e[18]});
      cmp({16'h0, llen}, e[18] ? 32'h50 : 32'h40);
      apb(1'h0, 12'h218, 32'h0, rd, err);
      cmp(rd, e);
    end
  endtask : s_caps
  task automatic s_mask;
    apb(1'h1, 12'h800, 32'h7e, rd, err);
    settle();
    cmp(cap, 32'h0);
    cmp({31'h0, exact}, 32'h1);
  endtask : s_mask
  task automatic s_rsv;
    apb(1'h1, 12'h21c, 32'hffffffff, rd, err);
    apb(1'h1, 12'h218, 32'hffffffff, rd, err);
    apb(1'h0, 12'h21c, 32'h0, rd, err);
    cmp({rd[30:0], err}, 32'h0);
    apb(1'h0, 12'h218, 32'h0, rd, err);
    cmp(rd, 32'h0);
    // unmapped read must flag an error and return nothing
    apb(1'h0, 12'h000, 32'h0, rd, err);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
    // unmapped write is refused with an error and no data
    apb(1'h1, 12'h000, 32'h5a5a5a5a, rd, err);
    cmp({31'h0, err}, 32'h1);
    cmp(rd, 32'h0);
  endtask : s_rsv
  task automatic s_name;
    apb(1'h1, 12'h300, 32'h00636261, rd, err);
    apb(1'h1, 12'h3fc, 32'hffeeddcc, rd, err);
    apb(1'h0, 12'h300, 32'h0, rd, err);
    cmp(rd, 32'h00636261);
    apb(1'h0, 12'h3fc, 32'h0, rd, err);
    cmp(rd, 32'h00eeddcc);
  endtask : s_name
  initial begin
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'h0;
    settle();
    cmp(cap, 32'h0);
    s_caps();
    s_mask();
    s_rsv();
    s_name();
    report_and_stop();
  end
endmodule : sglcap_report_bench
`default_nettype wire
